// [design/cmac_ctrl.sv]
// extension registers with clock mux, clock pin direction, host decode and cpu address remap
//
// Functional notes
// - direction set forces select msb to zero
// - source zero drives select bits on pins
// - direction clear makes upper pins selectable inputs
// - clock-zero-only takes first clock pin unless the ground or feature override applies
// - clock3 off with select 11 grounds clock
// - override off with select 10 picks feature
// - otherwise select fields choose the clock
// - page extension keeps bit0, upper read zero
// - page bit to linear bit0 in 64K mode
// - foreground colour applies in solid mode only
// - background colour applies in solid mode only
// - key value unlocks extension register access
// - setup enable, pin, bit0 set: full decode
// - setup bit0 clear: only setup port, no memory
// - setup enable clear: setup port not decoded
// - disable pin low ignores all host access
// - extra skew bit adds one character delay
// - sequential chain4 packs address, subs high bits
// - normal chain4 subs low two bits
// - sequential chain packs address, sub on bit15
// - sequential chain ignored outside chain mode
// - source one drives extended output bits
// - 128K mode puts address bit16 on bit0
`timescale 1ns/1ns
`default_nettype none
`include "cmac_defs.svh"

module cmac_ctrl
    import cmac_pkg::*;
(
    // clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // ahb-lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata_ff,
    output logic                    hreadyout_ff,
    output logic                    hresp_ff,
    // clock input pins
    input  wire logic               first_clock_pin,
    input  wire logic               second_clock_pin,
    input  wire logic               feature_clock_pin,
    input  wire logic               fourth_clock_pin,
    // upper clock pins, two-way
    input  wire logic [2:0]         upper_clock_pin_in,
    output cmac_upper_pins_t        upper_clock_pin_ff,
    // selected clock
    output logic                    dot_clock_ff,
    output logic      [2:0]         clock_src_ff,
    // host decode
    input  wire logic               host_enable_pin,
    input  wire logic               host_io_valid,
    input  wire logic [15:0]        host_io_addr,
    input  wire logic               host_mem_valid,
    output logic                    io_accept_ff,
    output logic                    mem_accept_ff,
    // cpu address remap
    input  wire logic [16:0]        cpu_addr,
    output logic      [15:0]        linear_addr_ff,
    // display side
    output logic      [3:0]         fg_colour_ff,
    output logic      [3:0]         bg_colour_ff,
    output logic                    solid_fb_ff,
    output logic      [2:0]         de_skew_ff
);

    // register state
    logic                   unlocked_ff;
    cmac_clkctl_t           clkctl_ff;
    logic                   clksel_hi_ff;
    logic                   page_ext_ff;
    logic [3:0]             fg_ff;
    logic [3:0]             bg_ff;
    cmac_compat_t           compat_ff;
    logic [1:0]             fbctl_ff;
    cmac_stdcfg_t           stdcfg_ff;

    // bus state
    cmac_bus_st_t           st_ff;
    logic [7:0]             idx_ff;
    logic                   addr_ok_ff;
    logic                   take;
    logic                   wr_en;
    logic                   ext_wr;
    logic [7:0]             wdat;
    logic [7:0]             rd_byte;

    // derived
    logic                   io_dec;
    logic                   mem_dec;
    logic [2:0]             nxt_clock_src;
    logic                   nxt_dot_clock;
    logic [2:0]             sel_raw;
    logic [2:0]             sel_eff;
    logic [15:0]            nxt_linear_addr;
    logic [1:0]             sub4;
    logic                   sub2;

    assign take   = hsel && htrans[1] && hready;
    assign wr_en  = (st_ff == ST_WR) && addr_ok_ff;
    assign ext_wr = wr_en && unlocked_ff;
    assign wdat   = hwdata[7:0];

    // bus phase tracking; reads take one wait state so a write just committed is visible
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff        <= ST_IDLE;
            idx_ff       <= 8'h00;
            addr_ok_ff   <= 1'b0;
            hreadyout_ff <= 1'b1;
        end
        else if (take)
        begin
            idx_ff       <= haddr[`CMAC_IDX_MSB:`CMAC_IDX_LSB];
            addr_ok_ff   <= (haddr[31:`CMAC_IDX_MSB+1] == 22'h000000) && (haddr[1:0] == 2'h0);
            st_ff        <= hwrite ? ST_WR : ST_RD;
            hreadyout_ff <= hwrite;
        end
        else
        begin
            st_ff        <= ST_IDLE;
            hreadyout_ff <= 1'b1;
        end
    end

    // response is always okay
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hresp_ff <= 1'b0;
        else
            hresp_ff <= 1'b0;
    end

    // read data captured at the end of the wait state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_ff <= 32'h00000000;
        else if (st_ff == ST_RD)
            hrdata_ff <= {24'h000000, rd_byte};
    end

    // read mux; locked extension registers read as zero
    always_comb
    begin
        rd_byte = 8'h00;
        if (!addr_ok_ff)
            rd_byte = 8'h00;
        else if (idx_ff == `CMAC_IDX_UNLOCK)
            rd_byte = {7'h00, unlocked_ff};
        else if (idx_ff == `CMAC_IDX_STDCFG)
            rd_byte = stdcfg_ff;
        else if (idx_ff == `CMAC_IDX_STATUS)
            rd_byte = {2'h0, unlocked_ff, mem_dec, io_dec, clock_src_ff};
        else if (!unlocked_ff)
            rd_byte = 8'h00;
        else if (idx_ff == `CMAC_IDX_CLKSEL)
            rd_byte = {3'h0, clksel_hi_ff, 4'h0};
        else if (idx_ff == `CMAC_IDX_CLKCTL)
            rd_byte = clkctl_ff;
        else if (idx_ff == `CMAC_IDX_PAGEXT)
            rd_byte = {7'h00, page_ext_ff};
        else if (idx_ff == `CMAC_IDX_FGCOL)
            rd_byte = {4'h0, fg_ff};
        else if (idx_ff == `CMAC_IDX_BGCOL)
            rd_byte = {4'h0, bg_ff};
        else if (idx_ff == `CMAC_IDX_COMPAT)
            rd_byte = compat_ff;
        else if (idx_ff == `CMAC_IDX_FBCTL)
            rd_byte = {4'h0, fbctl_ff, 2'h0};
    end

    // unlock: key opens, any other value closes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            unlocked_ff <= 1'b0;
        else if (wr_en && idx_ff == `CMAC_IDX_UNLOCK)
            unlocked_ff <= (wdat == `CMAC_UNLOCK_KEY);
    end

    // standard configuration is never locked
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            stdcfg_ff <= `CMAC_RST_STDCFG;
        else if (wr_en && idx_ff == `CMAC_IDX_STDCFG)
            stdcfg_ff <= wdat;
    end

    // clock registers; changing them glitches the dot clock, so software holds reset meanwhile
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            clkctl_ff    <= `CMAC_RST_CLKCTL;
            clksel_hi_ff <= 1'b0;
        end
        else
        begin
            if (ext_wr && idx_ff == `CMAC_IDX_CLKCTL)
                clkctl_ff <= wdat;
            if (ext_wr && idx_ff == `CMAC_IDX_CLKSEL)
                clksel_hi_ff <= wdat[`CMAC_CLKSEL_HI_BIT];
        end
    end

    // remaining extension registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            page_ext_ff <= 1'b0;
            fg_ff       <= `CMAC_RST_COLOUR;
            bg_ff       <= `CMAC_RST_COLOUR;
            compat_ff   <= `CMAC_RST_COMPAT;
            fbctl_ff    <= 2'h0;
        end
        else
        begin
            if (ext_wr && idx_ff == `CMAC_IDX_PAGEXT)
                page_ext_ff <= wdat[0];
            if (ext_wr && idx_ff == `CMAC_IDX_FGCOL)
                fg_ff <= wdat[3:0];
            if (ext_wr && idx_ff == `CMAC_IDX_BGCOL)
                bg_ff <= wdat[3:0];
            if (ext_wr && idx_ff == `CMAC_IDX_COMPAT)
                compat_ff <= wdat;
            if (ext_wr && idx_ff == `CMAC_IDX_FBCTL)
                fbctl_ff <= wdat[`CMAC_FBCTL_MSB:`CMAC_FBCTL_LSB];
        end
    end

    // clock source selection, overrides first
    assign sel_raw = {clksel_hi_ff, stdcfg_ff.misc_clk};
    assign sel_eff = {clksel_hi_ff & ~clkctl_ff.direction, stdcfg_ff.misc_clk};
    always_comb
    begin
        if (!clkctl_ff.clk3_on && stdcfg_ff.misc_clk == `CMAC_MISC_CLK3)
            nxt_clock_src = `CMAC_SRC_GND;
        else if (!clkctl_ff.ext_ovr && stdcfg_ff.misc_clk == `CMAC_MISC_FEAT)
            nxt_clock_src = `CMAC_SRC_FEATURE;
        else if (clkctl_ff.clk0_only)
            nxt_clock_src = `CMAC_SRC_FIRST;
        else
            nxt_clock_src = sel_eff;
    end

    // pin level of the chosen source; code 7 has no pin and stays grounded
    always_comb
    begin
        case (nxt_clock_src)
            3'h0:    nxt_dot_clock = first_clock_pin;
            3'h1:    nxt_dot_clock = second_clock_pin;
            3'h2:    nxt_dot_clock = feature_clock_pin;
            3'h3:    nxt_dot_clock = fourth_clock_pin;
            3'h4:    nxt_dot_clock = upper_clock_pin_in[0];
            3'h5:    nxt_dot_clock = upper_clock_pin_in[1];
            3'h6:    nxt_dot_clock = upper_clock_pin_in[2];
            default: nxt_dot_clock = 1'b0;
        endcase
    end

    // selected clock sampled into flops
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            clock_src_ff <= `CMAC_SRC_GND;
            dot_clock_ff <= 1'b0;
        end
        else
        begin
            clock_src_ff <= nxt_clock_src;
            dot_clock_ff <= nxt_dot_clock;
        end
    end

    // upper pins: outputs only while direction is set
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            upper_clock_pin_ff <= '0;
        else
        begin
            upper_clock_pin_ff.oe <= {3{clkctl_ff.direction}};
            if (clkctl_ff.out_src)
                upper_clock_pin_ff.out <= clkctl_ff.ext_out;
            else
                upper_clock_pin_ff.out <= sel_raw; // unforced msb goes out
        end
    end

    // host decode
    always_comb
    begin
        io_dec  = 1'b0;
        mem_dec = 1'b0;
        if (!host_enable_pin)
        begin
            io_dec  = 1'b0;
            mem_dec = 1'b0;
        end
        else if (compat_ff.setup_en)
        begin
            io_dec  = (host_io_addr == `CMAC_SETUP_PORT) ||
                      (stdcfg_ff.setup_bit0 && host_io_addr >= `CMAC_IO_LO && host_io_addr <= `CMAC_IO_HI);
            mem_dec = stdcfg_ff.setup_bit0;
        end
        else
        begin
            io_dec  = (host_io_addr != `CMAC_SETUP_PORT) &&
                      host_io_addr >= `CMAC_IO_LO && host_io_addr <= `CMAC_IO_HI;
            mem_dec = 1'b1;
        end
    end

    // host accept strobes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            io_accept_ff  <= 1'b0;
            mem_accept_ff <= 1'b0;
        end
        else
        begin
            io_accept_ff  <= host_io_valid && io_dec;
            mem_accept_ff <= host_mem_valid && mem_dec;
        end
    end

    // substituted bits for chain-4 and chain modes
    always_comb
    begin
        sub4 = cpu_addr[1:0];
        if (compat_ff.ext256_en && !compat_ff.ext256_mode)
            sub4 = {stdcfg_ff.page_sel, page_ext_ff};
        else if (compat_ff.ext256_en)
            sub4 = {stdcfg_ff.page_sel, cpu_addr[16]};
        sub2 = stdcfg_ff.page_sel;
    end

    // cpu to linear address map
    always_comb
    begin
        if (stdcfg_ff.chain4 && compat_ff.seq_chain4)
            nxt_linear_addr = {sub4, cpu_addr[15:2]};
        else if (stdcfg_ff.chain4)
            nxt_linear_addr = {cpu_addr[15:2], sub4};
        else if (stdcfg_ff.gr_chain && compat_ff.seq_chain)
            nxt_linear_addr = {sub2, cpu_addr[15:1]};
        else if (stdcfg_ff.gr_chain)
            nxt_linear_addr = {cpu_addr[15:1], sub2};
        else
            nxt_linear_addr = cpu_addr[15:0];
    end

    // linear address and display-side outputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            linear_addr_ff <= 16'h0000;
            solid_fb_ff    <= 1'b0;
            fg_colour_ff   <= `CMAC_RST_COLOUR;
            bg_colour_ff   <= `CMAC_RST_COLOUR;
            de_skew_ff     <= 3'h0;
        end
        else
        begin
            linear_addr_ff <= nxt_linear_addr;
            solid_fb_ff    <= (fbctl_ff == `CMAC_FB_SOLID);
            fg_colour_ff   <= (fbctl_ff == `CMAC_FB_SOLID) ? fg_ff : `CMAC_RST_COLOUR;
            bg_colour_ff   <= (fbctl_ff == `CMAC_FB_SOLID) ? bg_ff : `CMAC_RST_COLOUR;
            de_skew_ff     <= {1'b0, stdcfg_ff.crt_skew} + {2'h0, compat_ff.ext_skew};
        end
    end

    // checks
    AST_FORCE_MSB: assert property (@(posedge hclk) disable iff (!hresetn)
        clkctl_ff.direction |=> (!clock_src_ff[2] || clock_src_ff == `CMAC_SRC_GND))
        else $error("upper clock pin selected while pins are outputs");

    AST_PIN_SEL: assert property (@(posedge hclk) disable iff (!hresetn)
        (clkctl_ff.direction && !clkctl_ff.out_src) |=> upper_clock_pin_ff.out == $past(sel_raw))
        else $error("select bits not driven on upper pins");

    AST_PIN_EXT: assert property (@(posedge hclk) disable iff (!hresetn)
        (clkctl_ff.direction && clkctl_ff.out_src) |=>
        (upper_clock_pin_ff.out == $past(clkctl_ff.ext_out)) && (upper_clock_pin_ff.oe == 3'h7))
        else $error("extended output bits not driven on upper pins");

    AST_PIN_IN: assert property (@(posedge hclk) disable iff (!hresetn)
        !clkctl_ff.direction |=> upper_clock_pin_ff.oe == 3'h0)
        else $error("upper pins driven while inputs");

    AST_CLK0: assert property (@(posedge hclk) disable iff (!hresetn)
        (clkctl_ff.clk0_only && clkctl_ff.clk3_on && clkctl_ff.ext_ovr) |=>
        (clock_src_ff == `CMAC_SRC_FIRST) && (dot_clock_ff == $past(first_clock_pin)))
        else $error("clock zero only did not pick first pin");

    AST_GND: assert property (@(posedge hclk) disable iff (!hresetn)
        (!clkctl_ff.clk3_on && stdcfg_ff.misc_clk == `CMAC_MISC_CLK3) |=> !dot_clock_ff ##0 clock_src_ff == 3'h7)
        else $error("clock three not grounded");

    AST_FEAT: assert property (@(posedge hclk) disable iff (!hresetn)
        (!clkctl_ff.ext_ovr && stdcfg_ff.misc_clk == `CMAC_MISC_FEAT) |=>
        dot_clock_ff == $past(feature_clock_pin))
        else $error("feature clock override missed");

    AST_PAGEXT_RD: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff == ST_RD && idx_ff == `CMAC_IDX_PAGEXT) |=> hrdata_ff[31:1] == 31'h0 ##0 hreadyout_ff)
        else $error("page extension upper bits not zero");

    AST_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
        (!unlocked_ff && st_ff == ST_WR) |=> $stable(compat_ff) && $stable(clkctl_ff) && $stable(page_ext_ff))
        else $error("locked register changed");

    AST_DISABLE: assert property (@(posedge hclk) disable iff (!hresetn)
        !host_enable_pin |=> !io_accept_ff && !mem_accept_ff)
        else $error("access accepted while disabled");

    AST_SETUP_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
        (host_enable_pin && compat_ff.setup_en && !stdcfg_ff.setup_bit0 && host_mem_valid) |=> !mem_accept_ff)
        else $error("memory accepted in setup-only state");

    AST_SEQ4: assert property (@(posedge hclk) disable iff (!hresetn)
        (stdcfg_ff.chain4 && compat_ff.seq_chain4) |=> linear_addr_ff[13:0] == $past(cpu_addr[15:2]))
        else $error("sequential chain4 mapping wrong");

    AST_SKEW: assert property (@(posedge hclk) disable iff (!hresetn)
        compat_ff.ext_skew |=> de_skew_ff == $past(stdcfg_ff.crt_skew) + 3'h1)
        else $error("display enable skew not extended");

endmodule : cmac_ctrl
`default_nettype wire

// [design/cmac_defs.svh]
// register indices, field positions, reset values and decode constants for the clock/address control block
`ifndef CMAC_DEFS_SVH
`define CMAC_DEFS_SVH

// register indices; byte address on the bus is four times the index
`define CMAC_IDX_UNLOCK   8'h06
`define CMAC_IDX_STDCFG   8'h10
`define CMAC_IDX_STATUS   8'h11
`define CMAC_IDX_CLKSEL   8'ha4
`define CMAC_IDX_CLKCTL   8'hf8
`define CMAC_IDX_PAGEXT   8'hf9
`define CMAC_IDX_FGCOL    8'hfa
`define CMAC_IDX_BGCOL    8'hfb
`define CMAC_IDX_COMPAT   8'hfc
`define CMAC_IDX_FBCTL    8'hfe

// bus address layout
`define CMAC_IDX_LSB      2
`define CMAC_IDX_MSB      9

// extension unlock key
`define CMAC_UNLOCK_KEY   8'hea

// field positions
`define CMAC_CLKSEL_HI_BIT 4
`define CMAC_FBCTL_LSB     2
`define CMAC_FBCTL_MSB     3
`define CMAC_FB_SOLID      2'h1

// reset values
`define CMAC_RST_CLKCTL   8'h00
`define CMAC_RST_COMPAT   8'h00
`define CMAC_RST_STDCFG   8'h00
`define CMAC_RST_BYTE     8'h00
`define CMAC_RST_COLOUR   4'h0

// host decode
`define CMAC_SETUP_PORT   16'h03c3
`define CMAC_IO_LO        16'h03b0
`define CMAC_IO_HI        16'h03df

// clock source codes
`define CMAC_SRC_FIRST    3'h0
`define CMAC_SRC_FEATURE  3'h2
`define CMAC_SRC_GND      3'h7
`define CMAC_MISC_CLK3    2'h3
`define CMAC_MISC_FEAT    2'h2

`endif

// [design/cmac_pkg.sv]
// types shared by the clock/address control block
`default_nettype none
package cmac_pkg;

    // extended clock control layout, msb first
    typedef struct packed {
        logic [2:0] ext_out;
        logic       clk3_on;
        logic       ext_ovr;
        logic       out_src;
        logic       direction;
        logic       clk0_only;
    } cmac_clkctl_t;

    // compatibility control layout, msb first
    typedef struct packed {
        logic setup_en;
        logic ext_skew;
        logic seq_chain4;
        logic seq_chain;
        logic refresh_skew;
        logic ext256_en;
        logic ext256_mode;
        logic ext_attr;
    } cmac_compat_t;

    // standard-side configuration gathered in one register
    typedef struct packed {
        logic       setup_bit0;
        logic [1:0] crt_skew;
        logic       gr_chain;
        logic       chain4;
        logic       page_sel;
        logic [1:0] misc_clk;
    } cmac_stdcfg_t;

    // three upper clock pins as driven by the block
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe;
    } cmac_upper_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WR   = 3'b010,
        ST_RD   = 3'b100
    } cmac_bus_st_t;

endpackage : cmac_pkg
`default_nettype wire

// [dv/cmac_pin_model.sv]
// board-side model: free running clock sources and the two-way upper clock pins
`timescale 1ns/1ns
`default_nettype none
module cmac_pin_model
    import cmac_pkg::*;
(
    // pins as driven by the block
    input  wire cmac_upper_pins_t upper_pins,
    // board levels seen by the block
    output logic [3:0]            clk_pins,
    output logic [2:0]            upper_in
);
    logic [2:0] osc;

    // sources all step every 6 ns; upper pin 0 repeats the first clock pin, so a pick between those two is masked;
    // even-ns steps never meet a rising edge, so sampled and past levels agree
    initial
    begin
        clk_pins = 4'h0;
        osc      = 3'h0;
        forever
        begin
            #6;
            clk_pins = clk_pins + 4'h1;
            osc      = osc + 3'h3;
        end
    end

    // wire level: the block wins where it drives, else the board oscillator
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            upper_in[i] = upper_pins.oe[i] ? upper_pins.out[i] : osc[i];
        end
    end
endmodule : cmac_pin_model
`default_nettype wire

// [dv/tb.sv]
// self-checking bench: register access, clock mux, host decode, address remap, display outputs
`timescale 1ns/1ns
`default_nettype none
`include "cmac_defs.svh"
module tb
    import cmac_pkg::*;
;
    logic             hclk, hresetn, hsel, hwrite, hiv, hmv, hep;
    logic [31:0]      haddr, hwdata, hrdata;
    logic [1:0]       htrans;
    logic [15:0]      hia, lin;
    logic [16:0]      cpu;
    logic             hrdy, hresp, dclk, ioa, mema, solid;
    logic [3:0]       clks, fg, bg;
    logic [2:0]       upin, src, skew;
    logic [7:0]       lvl;
    cmac_upper_pins_t up;
    int               miscompares, n_compared;

    cmac_pin_model pin_u (.upper_pins(up), .clk_pins(clks), .upper_in(upin));

    cmac_ctrl dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata_ff(hrdata),
        .hreadyout_ff(hrdy), .hresp_ff(hresp), .first_clock_pin(clks[0]),
        .second_clock_pin(clks[1]), .feature_clock_pin(clks[2]), .fourth_clock_pin(clks[3]),
        .upper_clock_pin_in(upin), .upper_clock_pin_ff(up), .dot_clock_ff(dclk),
        .clock_src_ff(src), .host_enable_pin(hep), .host_io_valid(hiv), .host_io_addr(hia),
        .host_mem_valid(hmv), .io_accept_ff(ioa), .mem_accept_ff(mema), .cpu_addr(cpu),
        .linear_addr_ff(lin), .fg_colour_ff(fg), .bg_colour_ff(bg), .solid_fb_ff(solid),
        .de_skew_ff(skew)
    );

    // clock select cases: clock control, select msb reg, std config, expected source
    localparam logic [31:0] CLK_TAB [8] = '{32'h00000101, 32'h00000307, 32'h10000303,
        32'h01000202, 32'h09000200, 32'h19000300, 32'h00100105, 32'h02100101};
    // remap cases: std config, compat, cpu address, expected linear address
    localparam logic [55:0] MAP_TAB [7] = '{56'h08_00_00abcd_abcd, 56'h08_20_00abcd_6af3,
        56'h0c_04_01abcc_abcf, 56'h0c_06_00abcc_abce, 56'h14_10_00abcd_d5e6,
        56'h10_00_00abcc_abcc, 56'h18_10_00abcd_abcd};

    task automatic end_of_test();
        if (miscompares == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one single ahb transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {22'h0, idx, 2'h0};
        do @(posedge hclk); while (hrdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] x;
        xfer(1'b1, idx, d, x);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
        logic [31:0] x;
        xfer(1'b0, idx, 8'h00, x);
        chk(x, {24'h0, e});
        chk({31'h0, hresp}, 32'h0);
    endtask : rdc

    // registered outputs follow a register change after one more edge
    task automatic settle();
        repeat (2) @(posedge hclk);
        lvl = {1'b0, upin, clks};
        #1;
    endtask : settle

    // one host cycle carrying both an i/o and a memory request
    task automatic hreq(input logic [15:0] a, input logic eio, input logic emem);
        @(posedge hclk);
        hiv <= 1'b1;
        hmv <= 1'b1;
        hia <= a;
        @(posedge hclk);
        hiv <= 1'b0;
        hmv <= 1'b0;
        #1;
        chk({31'h0, ioa}, {31'h0, eio});
        chk({31'h0, mema}, {31'h0, emem});
    endtask : hreq

    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // watchdog: the tests need well under a thousand cycles
    initial
    begin
        #500000;
        miscompares++;
        end_of_test();
    end

    initial
    begin
        logic [31:0] t;
        logic [55:0] r;
        {hresetn, hsel, hwrite, hiv, hmv, htrans, haddr, hwdata, hia, cpu} = '0;
        hep = 1'b1;
        miscompares = 0;
        n_compared = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        // locked writes are dropped
        wr(`CMAC_IDX_COMPAT, 8'hff);
        rdc(`CMAC_IDX_COMPAT, 8'h00);
        wr(`CMAC_IDX_UNLOCK, `CMAC_UNLOCK_KEY);
        rdc(`CMAC_IDX_COMPAT, 8'h00);
        rdc(`CMAC_IDX_CLKCTL, `CMAC_RST_CLKCTL);
        rdc(`CMAC_IDX_PAGEXT, 8'h00);
        wr(`CMAC_IDX_PAGEXT, 8'hff);
        rdc(`CMAC_IDX_PAGEXT, 8'h01);
        rdc(8'h20, 8'h00);
        // lock again: reads hide, writes leave contents alone
        wr(`CMAC_IDX_FGCOL, 8'h0a);
        wr(`CMAC_IDX_UNLOCK, 8'h00);
        wr(`CMAC_IDX_FGCOL, 8'h03);
        rdc(`CMAC_IDX_FGCOL, 8'h00);
        wr(`CMAC_IDX_UNLOCK, `CMAC_UNLOCK_KEY);
        rdc(`CMAC_IDX_FGCOL, 8'h0a);
        // clock source selection and pin direction
        foreach (CLK_TAB[i])
        begin
            t = CLK_TAB[i];
            wr(`CMAC_IDX_CLKCTL, t[31:24]);
            wr(`CMAC_IDX_CLKSEL, t[23:16]);
            wr(`CMAC_IDX_STDCFG, t[15:8]);
            settle(); // no sequencer reset here, so clocks are judged only once settled
            chk({29'h0, src}, {29'h0, t[2:0]});
            chk({31'h0, dclk}, {31'h0, lvl[t[2:0]]});
            chk({29'h0, up.oe}, t[25] ? 32'h7 : 32'h0);
        end
        chk({26'h0, up}, 32'h2f);
        wr(`CMAC_IDX_CLKCTL, 8'h66);
        settle();
        chk({26'h0, up}, 32'h1f);
        // cpu to linear address remap
        foreach (MAP_TAB[i])
        begin
            r = MAP_TAB[i];
            wr(`CMAC_IDX_STDCFG, r[55:48]);
            wr(`CMAC_IDX_COMPAT, r[47:40]);
            cpu <= r[32:16];
            settle();
            chk({16'h0, lin}, {16'h0, r[15:0]});
        end
        // solid fg/bg colours only in mode 01
        wr(`CMAC_IDX_BGCOL, 8'h05);
        wr(`CMAC_IDX_FBCTL, 8'h04);
        settle();
        chk({23'h0, solid, fg, bg}, 32'h1a5);
        wr(`CMAC_IDX_FBCTL, 8'h08);
        settle();
        chk({23'h0, solid, fg, bg}, 32'h0);
        // display enable skew
        wr(`CMAC_IDX_STDCFG, 8'h60);
        wr(`CMAC_IDX_COMPAT, 8'h40);
        settle();
        chk({29'h0, skew}, 32'h4);
        wr(`CMAC_IDX_COMPAT, 8'h00);
        settle();
        chk({29'h0, skew}, 32'h3);
        // host decode
        wr(`CMAC_IDX_COMPAT, 8'h80);
        wr(`CMAC_IDX_STDCFG, 8'h80);
        rdc(`CMAC_IDX_COMPAT, 8'h80);
        hreq(`CMAC_SETUP_PORT, 1'b1, 1'b1);
        hreq(16'h03d4, 1'b1, 1'b1);
        wr(`CMAC_IDX_STDCFG, 8'h00);
        hreq(`CMAC_SETUP_PORT, 1'b1, 1'b0);
        hreq(16'h03d4, 1'b0, 1'b0);
        wr(`CMAC_IDX_COMPAT, 8'h00);
        hreq(`CMAC_SETUP_PORT, 1'b0, 1'b1);
        hreq(16'h03d4, 1'b1, 1'b1);
        @(posedge hclk) hep <= 1'b0;
        hreq(16'h03d4, 1'b0, 1'b0);
        rdc(`CMAC_IDX_STATUS, 8'h20);
        rdc(`CMAC_IDX_CLKSEL, 8'h10);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
